// [logic/wdt_top.sv]
// hardware watchdog: key sequence, prescaled 14-bit counter and reset pulse
//
// How it works
// - after any reset the watchdog is off and its counter holds at zero.
// - writing 1E then E1 to the service register at A6 enables it.
// - when enabled the counter advances once per 2^n machine cycles of twelve clocks, n being the prescale select.
// - once enabled nothing but reset or overflow turns it off.
// - fourteen-bit counter; the tick after 3FFE overflows and resets the whole device.
// - service register is write only; the count can't be read or loaded.
// - overflow drives an active-high reset pulse of 96 oscillator periods.
// - prescale register at A7 selects a 2^0..2^7 stretch of the timeout.
`timescale 1ns/1ps
`include "wdt_defines.svh"

module wdt_top (
    clk,
    rst_n,
    sfr_addr,
    sfr_wr,
    sfr_wdata,
    sfr_rd,
    sfr_rdata,
    wdt_active,
    wdt_rst_out
);
    import wdt_pkg::*;

    input  wire logic        clk;
    input  wire logic        rst_n;
    input  wire logic [7:0]  sfr_addr;
    input  wire logic        sfr_wr;
    input  wire logic [7:0]  sfr_wdata;
    input  wire logic        sfr_rd;
    output logic      [7:0]  sfr_rdata;
    output logic             wdt_active;
    output logic             wdt_rst_out;

    // ==========================================================
    // internal state
    wdt_key_t                    key_q;
    logic                        en_q;
    logic [`WDT_SEL_W-1:0]       prescale_q;
    logic [`WDT_MC_W-1:0]        mc_cnt;
    logic [`WDT_PRE_W-1:0]       pre_cnt;
    logic [`WDT_CNT_W-1:0]       wd_cnt;
    logic [`WDT_PULSE_W-1:0]     pulse_cnt;
    logic                        key_wr;
    logic                        pre_wr;
    logic                        svc;
    logic                        mc_tick;
    logic                        pre_tick;
    logic                        ovf_evt;
    logic [7:0]                  sel_one;
    logic [`WDT_PRE_W-1:0]       pre_mask;

    // ==========================================================
    // decode of cpu writes; the cpu is held in reset while the pulse runs
    assign key_wr = sfr_wr && (sfr_addr == `WDT_ADDR_SERVICE) && !wdt_rst_out;
    assign pre_wr = sfr_wr && (sfr_addr == `WDT_ADDR_PRESCALE) && !wdt_rst_out;

    // second key byte completes the sequence only when armed
    assign svc = key_wr && (key_q == WDT_KEY_ARMED)
                 && (sfr_wdata == `WDT_KEY_SECOND);

    // ==========================================================
    // key sequence tracker
    always_ff @(posedge clk) begin
        if (!rst_n || ovf_evt) begin
            key_q <= WDT_KEY_IDLE;
        end else if (key_wr) begin
            case (key_q)
                WDT_KEY_IDLE: begin
                    if (sfr_wdata == `WDT_KEY_FIRST) begin
                        key_q <= WDT_KEY_ARMED;
                    end
                end
                WDT_KEY_ARMED: begin
                    // a fresh first byte re-arms, anything else drops back
                    if (sfr_wdata == `WDT_KEY_FIRST) begin
                        key_q <= WDT_KEY_ARMED;
                    end else begin
                        key_q <= WDT_KEY_IDLE;
                    end
                end
                default: begin
                    key_q <= WDT_KEY_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // enable latch; no write path ever clears it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            en_q <= 1'b0;
        end else if (ovf_evt) begin
            en_q <= 1'b0;
        end else if (svc) begin
            en_q <= 1'b1;
        end
    end

    // ==========================================================
    // prescale select register, also cleared by the overflow reset
    always_ff @(posedge clk) begin
        if (!rst_n || ovf_evt) begin
            prescale_q <= `WDT_PRESCALE_RST;
        end else if (pre_wr) begin
            prescale_q <= sfr_wdata[`WDT_SEL_LSB +: `WDT_SEL_W];
        end
    end

    // ==========================================================
    // machine cycle divider: one tick every twelve oscillator periods
    assign mc_tick = en_q && (mc_cnt == `WDT_MC_LAST);

    wdt_counter #(.W(`WDT_MC_W)) u_mc (
        .clk   (clk),
        .rst_n (rst_n),
        .clr   (!en_q || svc || mc_tick),
        .inc   (en_q),
        .cnt   (mc_cnt)
    );

    // ==========================================================
    // prescaler: select n passes one tick in 2^n machine cycles
    assign sel_one  = 8'h01 << prescale_q;
    assign pre_mask = sel_one[`WDT_PRE_W-1:0] - 7'h01;
    assign pre_tick = mc_tick && ((pre_cnt & pre_mask) == pre_mask);

    wdt_counter #(.W(`WDT_PRE_W)) u_pre (
        .clk   (clk),
        .rst_n (rst_n),
        .clr   (!en_q || svc || pre_tick),
        .inc   (mc_tick),
        .cnt   (pre_cnt)
    );

    // ==========================================================
    // main count; the overflow fires on the tick that finds the count at 3FFE,
    // so at prescale select 0 a service every 16382 machine cycles is just enough
    assign ovf_evt = en_q && pre_tick
                     && (wd_cnt == (`WDT_CNT_TERM - 14'h0001));

    wdt_counter #(.W(`WDT_CNT_W)) u_wd (
        .clk   (clk),
        .rst_n (rst_n),
        .clr   (!en_q || svc || ovf_evt),
        .inc   (pre_tick),
        .cnt   (wd_cnt)
    );

    // ==========================================================
    // reset pulse length counter, idles at zero between pulses
    wdt_counter #(.W(`WDT_PULSE_W)) u_pulse (
        .clk   (clk),
        .rst_n (rst_n),
        .clr   (!wdt_rst_out),
        .inc   (wdt_rst_out),
        .cnt   (pulse_cnt)
    );

    // reset pin drive: high for exactly 96 clocks after an overflow
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wdt_rst_out <= 1'b0;
        end else if (ovf_evt) begin
            wdt_rst_out <= 1'b1;
        end else if (pulse_cnt == `WDT_PULSE_LAST) begin
            wdt_rst_out <= 1'b0;
        end
    end

    // ==========================================================
    // status out
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wdt_active <= 1'b0;
        end else begin
            wdt_active <= en_q && !ovf_evt;
        end
    end

    // ==========================================================
    // read data; the service address reads zero so the count never leaks
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd && (sfr_addr == `WDT_ADDR_PRESCALE)) begin
            sfr_rdata <= {5'h00, prescale_q};
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_off_after_reset;
        !$past(rst_n) |-> !en_q && (wd_cnt == '0) && !wdt_rst_out;
    endproperty
    a_off_after_reset: assert property (p_off_after_reset)
        else $error("watchdog not idle after reset");

    property p_hold_when_off;
        !en_q |=> (wd_cnt == '0);
    endproperty
    a_hold_when_off: assert property (p_hold_when_off)
        else $error("counter moved while disabled");

    // an overflow in either key cycle resets the tracker, so it is left out
    sequence s_first_key;
        key_wr && !ovf_evt && (sfr_wdata == `WDT_KEY_FIRST);
    endsequence
    sequence s_second_key;
        key_wr && !ovf_evt && (sfr_wdata == `WDT_KEY_SECOND);
    endsequence
    property p_key_enables;
        s_first_key ##1 s_second_key |=> en_q && (wd_cnt == '0) ##1 wdt_active;
    endproperty
    a_key_enables: assert property (p_key_enables)
        else $error("key pair did not enable and restart");

    property p_count_step;
        pre_tick && !svc && !ovf_evt |=> wd_cnt == $past(wd_cnt) + 14'h0001;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not step on its tick");

    // reference gap since the last tick or restart, kept apart from the divider;
    // a long repetition would be unrolled by the tools, a counter is cheap
    logic [`WDT_MC_W-1:0]        mc_gap_q;
    always_ff @(posedge clk) begin
        if (!rst_n || !en_q || svc || mc_tick) begin
            mc_gap_q <= '0;
        end else begin
            mc_gap_q <= mc_gap_q + 4'h1;
        end
    end

    property p_mc_spacing;
        en_q |-> (mc_tick == (mc_gap_q == 4'hB));
    endproperty
    a_mc_spacing: assert property (p_mc_spacing)
        else $error("machine cycle tick spacing wrong");

    property p_stays_on;
        en_q && !ovf_evt |=> en_q;
    endproperty
    a_stays_on: assert property (p_stays_on)
        else $error("watchdog switched off without overflow");

    property p_ovf_resets;
        ovf_evt |=> wdt_rst_out && !en_q && (wd_cnt == '0) && (prescale_q == '0);
    endproperty
    a_ovf_resets: assert property (p_ovf_resets)
        else $error("overflow did not reset the device");

    property p_pulse_len;
        $rose(wdt_rst_out) |-> ##95 wdt_rst_out ##1 !wdt_rst_out;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("reset pulse length not 96 clocks");

    property p_no_count_read;
        sfr_rd && (sfr_addr == `WDT_ADDR_SERVICE) |=> (sfr_rdata == 8'h00);
    endproperty
    a_no_count_read: assert property (p_no_count_read)
        else $error("service register returned data");

    property p_prescale_store;
        pre_wr && !ovf_evt |=> prescale_q == $past(sfr_wdata[`WDT_SEL_W-1:0]);
    endproperty
    a_prescale_store: assert property (p_prescale_store)
        else $error("prescale select not stored");

    property p_bad_key_drops;
        key_wr && (key_q == WDT_KEY_ARMED) && (sfr_wdata != `WDT_KEY_FIRST)
            && (sfr_wdata != `WDT_KEY_SECOND) |=> key_q == WDT_KEY_IDLE;
    endproperty
    a_bad_key_drops: assert property (p_bad_key_drops)
        else $error("wrong byte did not abandon the key");

endmodule

// [shared/wdt_defines.svh]
// constants for the hardware watchdog: addresses, keys, reset values and timing
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// ==========================================================
// special-function register addresses
`define WDT_ADDR_SERVICE   8'hA6
`define WDT_ADDR_PRESCALE  8'hA7

// ==========================================================
// key bytes of the enable / service sequence
`define WDT_KEY_FIRST      8'h1E
`define WDT_KEY_SECOND     8'hE1

// ==========================================================
// counter and field layout
`define WDT_CNT_W          14
`define WDT_CNT_TERM       14'h3FFF
`define WDT_PRE_W          7
`define WDT_SEL_W          3
`define WDT_SEL_LSB        0
`define WDT_PRESCALE_RST   3'h0

// ==========================================================
// timing: one oscillator period is one clk period
`define WDT_OSC_PERIOD_NS  25
`define WDT_OSC_PER_MC     12
`define WDT_MC_W           4
`define WDT_MC_LAST        4'(`WDT_OSC_PER_MC - 1)
`define WDT_PULSE_OSC      96
`define WDT_PULSE_W        7
`define WDT_PULSE_LAST     7'(`WDT_PULSE_OSC - 1)

`endif

// [shared/wdt_pkg.sv]
// types shared by the hardware watchdog files
package wdt_pkg;

    // ==========================================================
    // key sequence tracker, gray coded
    typedef enum logic [1:0] {
        WDT_KEY_IDLE  = 2'b00,
        WDT_KEY_ARMED = 2'b01
    } wdt_key_t;

endpackage

// [logic/wdt_counter.sv]
// up counter with synchronous clear, used for every divider of the watchdog
`timescale 1ns/1ps

module wdt_counter #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         clr,
    input  wire logic         inc,
    output logic     [W-1:0]  cnt
);

    // ==========================================================
    // count state; clear wins over increment
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (clr) begin
            cnt <= '0;
        end else if (inc) begin
            cnt <= cnt + W'(1);
        end
    end

endmodule

// [tb/test_wdt_top.sv]
// self-checking bench for the hardware watchdog: key sequence, reads and reset behaviour
`timescale 1ns/1ps
`include "wdt_defines.svh"

module test_wdt_top;
    import wdt_pkg::*;

    // ==========================================================
    // stimulus and observed signals
    logic        clk;
    logic        rst_n;
    logic [7:0]  sfr_addr;
    logic        sfr_wr;
    logic [7:0]  sfr_wdata;
    logic        sfr_rd;
    logic [7:0]  sfr_rdata;
    logic        wdt_active;
    logic        wdt_rst_out;
    int          n_fail;
    int          n_tests;
    logic [7:0]  rd_val;

    wdt_top i_wdt_top (
        .clk         (clk),
        .rst_n       (rst_n),
        .sfr_addr    (sfr_addr),
        .sfr_wr      (sfr_wr),
        .sfr_wdata   (sfr_wdata),
        .sfr_rd      (sfr_rd),
        .sfr_rdata   (sfr_rdata),
        .wdt_active  (wdt_active),
        .wdt_rst_out (wdt_rst_out)
    );

    // ==========================================================
    // 40 MHz oscillator
    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // ==========================================================
    // comparison and verdict
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==========================================================
    // access tasks; inputs move 2 ns after the rising edge
    task automatic do_reset();
        @(posedge clk);
        #2 rst_n = 1'b0;
        repeat (5) @(posedge clk);
        #2 rst_n = 1'b1;
    endtask

    // single write, strobe high for exactly one sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #2;
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(posedge clk);
        #2 sfr_wr = 1'b0;
    endtask

    // read data is registered: valid just after the edge that takes the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #2;
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(posedge clk);
        #2;
        sfr_rd = 1'b0;
        d      = sfr_rdata;
    endtask

    // enable flag lags the second key by a couple of edges
    task automatic chk_active(input logic exp);
        repeat (3) @(posedge clk);
        #2;
        chk({7'h00, wdt_active}, {7'h00, exp}, "enable flag");
        chk({7'h00, wdt_rst_out}, 8'h00, "reset pin");
    endtask

    // ==========================================================
    // hang guard, far beyond the length of the tests
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        $display("CHECK FAILED t=%0t bench timed out", $time);
        conclude();
    end

    // ==========================================================
    // main sequence
    initial begin
        n_fail    = 0;
        n_tests   = 0;
        rst_n     = 1'b0;
        sfr_addr  = 8'h00;
        sfr_wr    = 1'b0;
        sfr_wdata = 8'h00;
        sfr_rd    = 1'b0;
        repeat (5) @(posedge clk);
        #2 rst_n = 1'b1;

        // comes up off; no address returns a count
        chk_active(1'b0);
        for (int a = 8'hA0; a <= 8'hA8; a++) begin
            rd(8'(a), rd_val);
            chk(rd_val, 8'h00, "read after reset");
        end
        $display("test reset_state done");

        // wrong byte between keys abandons the sequence
        wr(`WDT_ADDR_SERVICE, `WDT_KEY_FIRST);
        wr(`WDT_ADDR_SERVICE, 8'h5A);
        wr(`WDT_ADDR_SERVICE, `WDT_KEY_SECOND);
        chk_active(1'b0);
        // second key alone does nothing either
        wr(`WDT_ADDR_SERVICE, `WDT_KEY_SECOND);
        chk_active(1'b0);
        $display("test abandon done");

        // repeated first key re-arms; other addresses may sit between the keys
        wr(`WDT_ADDR_SERVICE, `WDT_KEY_FIRST);
        wr(`WDT_ADDR_SERVICE, `WDT_KEY_FIRST);
        wr(`WDT_ADDR_PRESCALE, 8'hFD);
        wr(`WDT_ADDR_SERVICE, `WDT_KEY_SECOND);
        chk_active(1'b1);
        rd(`WDT_ADDR_PRESCALE, rd_val);
        chk(rd_val, 8'h05, "prescale select");
        rd(`WDT_ADDR_SERVICE, rd_val);
        chk(rd_val, 8'h00, "service read");
        $display("test enable done");

        // nothing written can switch it off again
        wr(`WDT_ADDR_SERVICE, 8'h00);
        wr(`WDT_ADDR_SERVICE, 8'hFF);
        wr(`WDT_ADDR_PRESCALE, 8'h00);
        wr(`WDT_ADDR_SERVICE, `WDT_KEY_SECOND);
        chk_active(1'b1);
        // back-to-back service pair keeps it running
        @(posedge clk);
        #2;
        sfr_addr  = `WDT_ADDR_SERVICE;
        sfr_wdata = `WDT_KEY_FIRST;
        sfr_wr    = 1'b1;
        @(posedge clk);
        #2 sfr_wdata = `WDT_KEY_SECOND;
        @(posedge clk);
        #2 sfr_wr = 1'b0;
        chk_active(1'b1);
        rd(`WDT_ADDR_PRESCALE, rd_val);
        chk(rd_val, 8'h00, "prescale rewritten");
        $display("test stays_on done");

        // hardware reset in mid-run disables and clears the select
        wr(`WDT_ADDR_PRESCALE, 8'h06);
        rd(`WDT_ADDR_PRESCALE, rd_val);
        chk(rd_val, 8'h06, "prescale before reset");
        do_reset();
        chk_active(1'b0);
        rd(`WDT_ADDR_PRESCALE, rd_val);
        chk(rd_val, 8'h00, "prescale after reset");
        $display("test second_reset done");

        conclude();
    end

endmodule
